// file: ssr_top.sv
`timescale 1ns/1ps
// Summary of operation
// - Condition registers follow live state, read-only
// - Event bits latch edges, no counting
// - Event bits stay until query or clear
// - Enable masks select bits into summary
// - Clear-status clears events, keeps enables
// - Preset clears group enable masks
// - Message-available bit follows output buffer data
// - Clearing group events clears its summary bit
// - Bit 2 set while error queue nonempty
// - Bit 3 is enabled questionable summary
// - Bit 5 is enabled standard-event summary
// - Bit 6 is enabled status byte summary
// - Service-request-enable writes summary mask
// - Power-on clears mask only when setting is 1
// - Master bit rising raises service request
// - Serial poll clears request bit and line
// - Byte query keeps master bit and request
module ssr_top #(
   parameter int QW = ssr_pkg::QUES_W,
   parameter int SW = ssr_pkg::STD_W
) (
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   input  wire logic [QW-1:0]             ques_condition,
   input  wire logic [SW-1:0]             std_condition,
   input  wire logic                      err_queue_nonempty,
   input  wire logic                      out_buf_has_data,
   input  wire logic                      clear_status_command,
   input  wire logic                      status_preset_command,
   input  wire logic                      questionable_event_query,
   input  wire logic                      ques_enable_write,
   input  wire logic [QW-1:0]             ques_enable_wdata,
   input  wire logic                      std_event_query,
   input  wire logic                      std_enable_write,
   input  wire logic [SW-1:0]             std_enable_wdata,
   input  wire logic                      service_request_enable_command,
   input  wire logic [ssr_pkg::STB_W-1:0] srq_enable_wdata,
   input  wire logic                      power_on_clear_setting,
   input  wire logic [ssr_pkg::STB_W-1:0] retained_enable_mask,
   input  wire logic                      summary_byte_query,
   input  wire logic                      serial_poll,
   output logic      [QW-1:0]             ques_condition_rdata,
   output logic      [QW-1:0]             ques_event_rdata,
   output logic      [QW-1:0]             ques_enable_rdata,
   output logic      [SW-1:0]             std_event_rdata,
   output logic      [SW-1:0]             std_enable_rdata,
   output logic      [ssr_pkg::STB_W-1:0] summary_enable_mask,
   output logic      [ssr_pkg::STB_W-1:0] status_summary_byte,
   output logic      [ssr_pkg::STB_W-1:0] serial_poll_byte,
   output logic                           srq
);

   // ****************************************
   // Register groups
   // ****************************************

   ssr_grp_if #(.W(QW)) qg ();
   ssr_grp_if #(.W(SW)) sg ();

   // Clear-status and preset fan out to both groups
   // clear-status events, preset enables
   assign qg.cond     = ques_condition;
   assign qg.ev_rd    = questionable_event_query;
   assign qg.cls      = clear_status_command;
   assign qg.pres     = status_preset_command;
   assign qg.en_we    = ques_enable_write;
   assign qg.en_wdata = ques_enable_wdata;

   assign sg.cond     = std_condition;
   assign sg.ev_rd    = std_event_query;
   assign sg.cls      = clear_status_command;
   assign sg.pres     = status_preset_command;
   assign sg.en_we    = std_enable_write;
   assign sg.en_wdata = std_enable_wdata;

   ssr_event_group #(.W(QW)) u_ques (
      .clk   (clk),
      .rst_n (rst_n),
      .g     (qg.grp)
   );

   ssr_event_group #(.W(SW)) u_std (
      .clk   (clk),
      .rst_n (rst_n),
      .g     (sg.grp)
   );

   assign ques_condition_rdata = qg.cond_rdata;
   assign ques_event_rdata     = qg.ev_rdata;
   assign ques_enable_rdata    = qg.en_rdata;
   assign std_event_rdata      = sg.ev_rdata;
   assign std_enable_rdata     = sg.en_rdata;

   // ****************************************
   // Status byte condition
   // ****************************************

   logic [ssr_pkg::STB_W-1:0] stb_cond;
   logic [ssr_pkg::STB_W-1:0] stb_full;
   logic                      master;
   logic                      master_q;
   logic                      request_service_bit;
   logic                      init_done;

   // Rebuilt each cycle; a cleared group event drops its bit two cycles later
   // summary follows events
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         stb_cond <= ssr_pkg::STB_RST;
      end else begin
         stb_cond                       <= ssr_pkg::STB_RST;
         stb_cond[ssr_pkg::STB_ERR_BIT] <= err_queue_nonempty;
         stb_cond[ssr_pkg::STB_QUE_BIT] <= qg.summary;
         stb_cond[ssr_pkg::STB_MAV_BIT] <= out_buf_has_data;
         stb_cond[ssr_pkg::STB_STD_BIT] <= sg.summary;
      end
   end

   // Only bits 5..2 can ever be set, so masking the whole byte is safe
   // master summary
   assign master = |(stb_cond & summary_enable_mask);

   // Unused bits 0, 1 and 7 stay at zero
   // unused bits zero
   always_comb begin
      stb_full                       = stb_cond;
      stb_full[ssr_pkg::STB_MSS_BIT] = master;
   end

   // ****************************************
   // Summary enable mask
   // ****************************************

   // Async reset may only load a constant, so the retained mask is
   // taken on the first clock after release instead
   // conditional power-on clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         init_done           <= 1'b0;
         summary_enable_mask <= ssr_pkg::MASK_RST;
      end else if (!init_done) begin
         init_done           <= 1'b1;
         summary_enable_mask <= power_on_clear_setting ? ssr_pkg::MASK_RST
                                                       : retained_enable_mask;
      end else if (service_request_enable_command) begin
         summary_enable_mask <= srq_enable_wdata;
      end
   end

   // ****************************************
   // Service request
   // ****************************************

   // A new rise beats a poll in the same cycle, so no request is lost
   // rise raises request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         master_q <= 1'b0;
         request_service_bit      <= 1'b0;
      end else begin
         master_q <= master;
         if (master && !master_q) begin
            request_service_bit <= 1'b1;
         end else if (serial_poll) begin
            request_service_bit <= 1'b0;
         end
      end
   end

   assign srq = request_service_bit;

   // ****************************************
   // Read-back bytes
   // ****************************************

   // Poll reports the request bit; byte query reports live master summary
   // and leaves the request alone
   // query keeps request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_summary_byte <= ssr_pkg::STB_RST;
         serial_poll_byte    <= ssr_pkg::STB_RST;
      end else begin
         if (summary_byte_query) begin
            status_summary_byte <= stb_full;
         end
         if (serial_poll) begin
            serial_poll_byte                       <= stb_full;
            serial_poll_byte[ssr_pkg::STB_MSS_BIT] <= request_service_bit;
         end
      end
   end

   // ****************************************
   // Checks
   // ****************************************

   sequence s_err_seen;
      err_queue_nonempty;
   endsequence

   property p_err_bit;
      @(posedge clk) disable iff (!rst_n)
      s_err_seen |=> stb_cond[ssr_pkg::STB_ERR_BIT];
   endproperty
   a_err_bit: assert property (p_err_bit)
      else $error("error queue bit missing");

   property p_mav;
      @(posedge clk) disable iff (!rst_n)
      out_buf_has_data != stb_cond[ssr_pkg::STB_MAV_BIT]
         |-> $past(out_buf_has_data) == stb_cond[ssr_pkg::STB_MAV_BIT];
   endproperty
   a_mav: assert property (p_mav)
      else $error("message available bit wrong");

   property p_ques_bit;
      @(posedge clk) disable iff (!rst_n)
      qg.summary |=> stb_cond[ssr_pkg::STB_QUE_BIT];
   endproperty
   a_ques_bit: assert property (p_ques_bit)
      else $error("questionable bit missing");

   property p_std_bit;
      @(posedge clk) disable iff (!rst_n)
      !sg.summary |=> !stb_cond[ssr_pkg::STB_STD_BIT];
   endproperty
   a_std_bit: assert property (p_std_bit)
      else $error("standard bit set without summary");

   property p_unused;
      @(posedge clk) disable iff (!rst_n)
      summary_byte_query |=> !status_summary_byte[7] &&
         status_summary_byte[1:0] == 2'b00;
   endproperty
   a_unused: assert property (p_unused)
      else $error("unused status bits set");

   sequence s_master_rise;
      master && !master_q;
   endsequence

   property p_srq_rise;
      @(posedge clk) disable iff (!rst_n)
      s_master_rise |=> srq;
   endproperty
   a_srq_rise: assert property (p_srq_rise)
      else $error("service request not raised");

   property p_poll_clr;
      @(posedge clk) disable iff (!rst_n)
      (serial_poll && !(master && !master_q)) |=> !srq;
   endproperty
   a_poll_clr: assert property (p_poll_clr)
      else $error("poll did not release request");

   property p_query_keep;
      @(posedge clk) disable iff (!rst_n)
      (summary_byte_query && !serial_poll && srq) |=> srq
         ##0 status_summary_byte[ssr_pkg::STB_MSS_BIT] == $past(master);
   endproperty
   a_query_keep: assert property (p_query_keep)
      else $error("byte query disturbed request");

   property p_sre_wr;
      @(posedge clk) disable iff (!rst_n)
      (init_done && service_request_enable_command)
         |=> summary_enable_mask == $past(srq_enable_wdata);
   endproperty
   a_sre_wr: assert property (p_sre_wr)
      else $error("summary mask write lost");

   property p_psc;
      @(posedge clk) disable iff (!rst_n)
      (!init_done && power_on_clear_setting) |=> summary_enable_mask == ssr_pkg::MASK_RST;
   endproperty
   a_psc: assert property (p_psc)
      else $error("power-on clear ignored");

   property p_psc_keep;
      @(posedge clk) disable iff (!rst_n)
      (!init_done && !power_on_clear_setting)
         |=> summary_enable_mask == $past(retained_enable_mask);
   endproperty
   a_psc_keep: assert property (p_psc_keep)
      else $error("retained summary mask lost");

   sequence s_enabled_summary;
      (stb_cond[ssr_pkg::STB_ERR_BIT] && summary_enable_mask[ssr_pkg::STB_ERR_BIT]) ||
      (stb_cond[ssr_pkg::STB_QUE_BIT] && summary_enable_mask[ssr_pkg::STB_QUE_BIT]) ||
      (stb_cond[ssr_pkg::STB_MAV_BIT] && summary_enable_mask[ssr_pkg::STB_MAV_BIT]) ||
      (stb_cond[ssr_pkg::STB_STD_BIT] && summary_enable_mask[ssr_pkg::STB_STD_BIT]);
   endsequence

   property p_master;
      @(posedge clk) disable iff (!rst_n)
      s_enabled_summary |-> stb_full[ssr_pkg::STB_MSS_BIT];
   endproperty
   a_master: assert property (p_master)
      else $error("master summary bit missing");

   // cleared events drop bit
   // With no new edge in the clearing cycle the bit must be gone three edges on
   property p_ques_clear;
      @(posedge clk) disable iff (!rst_n)
      ((clear_status_command || questionable_event_query) &&
         ques_condition == ques_condition_rdata)
         |-> ##3 !stb_cond[ssr_pkg::STB_QUE_BIT];
   endproperty
   a_ques_clear: assert property (p_ques_clear)
      else $error("questionable bit kept after clear");

endmodule

// file: ssr_pkg.sv
package ssr_pkg;
   // Group widths
   localparam int QUES_W = 16;
   localparam int STD_W  = 8;
   localparam int STB_W  = 8;

   // Status byte bit positions
   localparam int STB_ERR_BIT = 2;
   localparam int STB_QUE_BIT = 3;
   localparam int STB_MAV_BIT = 4;
   localparam int STB_STD_BIT = 5;
   localparam int STB_MSS_BIT = 6;

   // Summary field that the enable mask can select (bits 5..2)
   localparam int STB_LO = STB_ERR_BIT;
   localparam int STB_HI = STB_STD_BIT;

   // Reset values
   localparam logic [STB_W-1:0] STB_RST  = 8'h00;
   localparam logic [STB_W-1:0] MASK_RST = 8'h00;
endpackage

// file: ssr_grp_if.sv
`timescale 1ns/1ps
// Command and result bundle for one register group
interface ssr_grp_if #(parameter int W = 16);
   logic [W-1:0] cond;
   logic         ev_rd;
   logic         cls;
   logic         pres;
   logic         en_we;
   logic [W-1:0] en_wdata;
   logic         summary;
   logic [W-1:0] ev_rdata;
   logic [W-1:0] cond_rdata;
   logic [W-1:0] en_rdata;

   modport grp (
      input  cond, ev_rd, cls, pres, en_we, en_wdata,
      output summary, ev_rdata, cond_rdata, en_rdata
   );
   modport ctl (
      output cond, ev_rd, cls, pres, en_we, en_wdata,
      input  summary, ev_rdata, cond_rdata, en_rdata
   );
endinterface

// file: ssr_event_group.sv
`timescale 1ns/1ps
module ssr_event_group #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst_n,
   ssr_grp_if.grp   g
);

   logic [W-1:0] cond_q;
   logic [W-1:0] ev;
   logic [W-1:0] en;
   logic [W-1:0] rise;

   // Rising edges of the live condition are the events
   assign rise = g.cond & ~cond_q;

   // ****************************************
   // Condition tracking
   // ****************************************

   // Previous condition, for edge detection; read-back is a plain copy
   // live read-only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cond_q       <= '0;
         g.cond_rdata <= '0;
      end else begin
         cond_q       <= g.cond;
         g.cond_rdata <= g.cond;
      end
   end

   // ****************************************
   // Event latch
   // ****************************************

   // A new edge in the clearing cycle survives: set wins over clear
   // latch, no counting
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ev <= '0;
      end else if (g.cls || g.ev_rd) begin
         ev <= rise;
      end else begin
         ev <= ev | rise;
      end
   end

   // Query returns the value held before the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         g.ev_rdata <= '0;
      end else if (g.ev_rd) begin
         g.ev_rdata <= ev;
      end
   end

   // ****************************************
   // Enable mask and summary
   // ****************************************

   // Preset beats a write in the same cycle; clear-status never touches it
   // enable mask
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         en <= '0;
      end else if (g.pres) begin
         en <= '0;
      end else if (g.en_we) begin
         en <= g.en_wdata;
      end
   end

   assign g.en_rdata = en;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         g.summary <= 1'b0;
      end else begin
         g.summary <= |(ev & en);
      end
   end

   // ****************************************
   // Checks
   // ****************************************

   property p_ev_hold;
      @(posedge clk) disable iff (!rst_n)
      !(g.ev_rd || g.cls) |=> (($past(ev) & ~ev) == '0);
   endproperty
   a_ev_hold: assert property (p_ev_hold)
      else $error("event bit dropped without a clear");

   property p_ev_latch;
      @(posedge clk) disable iff (!rst_n)
      (|rise) |=> (($past(rise) & ~ev) == '0);
   endproperty
   a_ev_latch: assert property (p_ev_latch)
      else $error("condition edge not latched");

   property p_cls;
      @(posedge clk) disable iff (!rst_n)
      (g.cls && rise == '0 && !g.pres && !g.en_we) |=> (ev == '0) && $stable(en);
   endproperty
   a_cls: assert property (p_cls)
      else $error("clear status wrong");

   property p_pres;
      @(posedge clk) disable iff (!rst_n)
      g.pres |=> (en == '0);
   endproperty
   a_pres: assert property (p_pres)
      else $error("preset left enable bits");

   property p_en_wr;
      @(posedge clk) disable iff (!rst_n)
      (g.en_we && !g.pres) |=> (en == $past(g.en_wdata));
   endproperty
   a_en_wr: assert property (p_en_wr)
      else $error("enable write not stored");

endmodule

// file: ssr_host_model.sv
`timescale 1ns/1ps
// ************************************************************
// Remote host: answers a service request with a serial poll
// ************************************************************
module ssr_host_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       srq,
   input  wire logic [3:0] poll_wait,
   output logic            serial_poll
);
   int cnt;

   initial serial_poll = 1'b0;

   // Poll poll_wait cycles after the request is seen; 4'hf means the host
   // ignores the line, and the count restarts so a later wait value still hits
   always @(negedge clk) begin
      if (!rst_n || !srq || poll_wait == 4'hf) begin
         cnt = 0;
         serial_poll <= 1'b0;
      end else begin
         serial_poll <= (cnt == poll_wait) && (poll_wait != 4'hf);
         cnt = cnt + 1;
      end
   end
endmodule

// file: ssr_top_bench.sv
`timescale 1ns/1ps
module ssr_top_bench;
   logic        clk, rst_n, err_queue_nonempty, out_buf_has_data;
   logic        clear_status_command, status_preset_command;
   logic        questionable_event_query, ques_enable_write;
   logic        std_event_query, std_enable_write, service_request_enable_command;
   logic        power_on_clear_setting, summary_byte_query, serial_poll, srq;
   logic [15:0] ques_condition, ques_enable_wdata, ques_condition_rdata;
   logic [15:0] ques_event_rdata, ques_enable_rdata;
   logic [7:0]  std_condition, std_enable_wdata, srq_enable_wdata;
   logic [7:0]  retained_enable_mask, std_event_rdata, std_enable_rdata;
   logic [7:0]  summary_enable_mask, status_summary_byte, serial_poll_byte;
   logic [3:0]  poll_wait;
   int          mismatches, cmp_count;

   ssr_top i_dut (
      .clk, .rst_n, .ques_condition, .std_condition, .err_queue_nonempty,
      .out_buf_has_data, .clear_status_command, .status_preset_command,
      .questionable_event_query, .ques_enable_write, .ques_enable_wdata,
      .std_event_query, .std_enable_write, .std_enable_wdata,
      .service_request_enable_command, .srq_enable_wdata,
      .power_on_clear_setting, .retained_enable_mask, .summary_byte_query,
      .serial_poll, .ques_condition_rdata, .ques_event_rdata,
      .ques_enable_rdata, .std_event_rdata, .std_enable_rdata,
      .summary_enable_mask, .status_summary_byte, .serial_poll_byte, .srq
   );

   ssr_host_model i_host (.clk, .rst_n, .srq, .poll_wait, .serial_poll);

   // ************************************************************
   // Clock, watchdog and verdict
   // ************************************************************
   // 200 MHz system clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Whole run is just over a hundred cycles; 4000 leaves a wide margin
   initial begin
      #20000;
      mismatches++;
      test_done();
   end

   task automatic test_done();
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ************************************************************
   // Access tasks
   // ************************************************************
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Strobe high for exactly one rising edge, launched at a falling edge
   task automatic pulse(ref logic s);
      @(negedge clk);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic rd_stb(input logic [7:0] exp);
      idle(3);
      pulse(summary_byte_query);
      chk(status_summary_byte, exp);
   endtask

   task automatic wr_sre(input logic [7:0] v);
      srq_enable_wdata = v;
      pulse(service_request_enable_command);
      chk(summary_enable_mask, v);
   endtask

   // Bounded wait for the service request line to reach a level
   task automatic wait_srq(input logic lvl);
      int n;
      n = 0;
      while (srq !== lvl && n < 20) begin
         @(negedge clk);
         n++;
      end
      chk(srq, lvl);
   endtask

   task automatic do_reset(input logic setting);
      rst_n = 1'b0;
      power_on_clear_setting = setting;
      idle(16);
      chk(srq, 1'b0);
      chk(status_summary_byte, 8'h00);
      rst_n = 1'b1;
      idle(2);
   endtask

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      {err_queue_nonempty, out_buf_has_data, clear_status_command} = '0;
      {status_preset_command, questionable_event_query} = '0;
      {ques_enable_write, std_event_query, std_enable_write} = '0;
      {service_request_enable_command, summary_byte_query} = '0;
      {ques_condition, ques_enable_wdata, std_condition} = '0;
      {std_enable_wdata, srq_enable_wdata} = '0;
      retained_enable_mask = 8'h24;
      poll_wait = 4'hf;
      mismatches = 0;
      cmp_count = 0;
      do_reset(1'b1);
      chk(summary_enable_mask, 8'h00);
      // Questionable path up to the service request
      ques_enable_wdata = 16'h0001;
      pulse(ques_enable_write);
      chk(ques_enable_rdata, 16'h0001);
      wr_sre(8'h08);
      @(negedge clk);
      ques_condition = 16'h0201;
      idle(2);
      chk(ques_condition_rdata, 16'h0201);
      wait_srq(1'b1);
      rd_stb(8'h48);
      chk(srq, 1'b1);
      poll_wait = 4'h2;
      wait_srq(1'b0);
      chk(serial_poll_byte, 8'h48);
      poll_wait = 4'hf;
      rd_stb(8'h48);
      // A second edge on a set bit must not queue anything
      ques_condition = 16'h0200;
      idle(2);
      ques_condition = 16'h0201;
      idle(2);
      pulse(questionable_event_query);
      chk(ques_event_rdata, 16'h0201);
      chk(ques_condition_rdata, 16'h0201);
      rd_stb(8'h00);
      pulse(questionable_event_query);
      chk(ques_event_rdata, 16'h0000);
      // Standard group, error queue and output buffer
      std_enable_wdata = 8'h01;
      pulse(std_enable_write);
      wr_sre(8'h20);
      @(negedge clk);
      std_condition = 8'h01;
      err_queue_nonempty = 1'b1;
      out_buf_has_data = 1'b1;
      rd_stb(8'h74);
      wait_srq(1'b1);
      pulse(clear_status_command);
      rd_stb(8'h14);
      chk(std_enable_rdata, 8'h01);
      chk(ques_enable_rdata, 16'h0001);
      pulse(std_event_query);
      chk(std_event_rdata, 8'h00);
      wr_sre(8'h04);
      rd_stb(8'h54);
      pulse(status_preset_command);
      chk(ques_enable_rdata, 16'h0000);
      chk(std_enable_rdata, 8'h00);
      wr_sre(8'h00);
      rd_stb(8'h14);
      err_queue_nonempty = 1'b0;
      out_buf_has_data = 1'b0;
      rd_stb(8'h00);
      // Power-on with the clear setting off keeps the stored mask
      do_reset(1'b0);
      chk(summary_enable_mask, 8'h24);
      test_done();
   end
endmodule
